//--- common/nps_pkg.sv
// Purpose: constants shared by the pvc status manager files
// Assumes: 25 MHz ref_clk, apb register map
// Notes: timers count whole seconds
package nps_pkg;
   // clock and time base
   localparam int CLK_HZ = 25_000_000;
   localparam int SEC_S = 1;
   localparam int SEC_CYC = SEC_S * CLK_HZ;
   // link parameter defaults and ranges
   localparam logic [7:0] FSP_DEF = 8'h06;
   localparam logic [7:0] FSP_MIN = 8'h01;
   localparam logic [3:0] ERR_DEF = 4'h3;
   localparam logic [3:0] EVT_DEF = 4'h4;
   localparam logic [3:0] CNT_MIN = 4'h1;
   localparam logic [3:0] CNT_MAX = 4'ha;
   localparam logic [4:0] PT_DEF_S = 5'h0a;
   localparam logic [4:0] PVT_DEF_S = 5'h0f;
   localparam logic [4:0] T_MIN_S = 5'h05;
   localparam logic [4:0] T_MAX_S = 5'h1e;
   localparam int WIN_MAX = 10;
   // register byte offsets
   localparam logic [7:0] A_CFG = 8'h00;
   localparam logic [7:0] A_CTRL = 8'h04;
   localparam logic [7:0] A_PVC = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0c;
   // cfg field positions
   localparam int F_FSP = 0;
   localparam int F_ERR = 8;
   localparam int F_EVT = 12;
   localparam int F_PT = 16;
   localparam int F_PVT = 21;
   localparam logic [31:0] CFG_RST = {6'h00, PVT_DEF_S, PT_DEF_S, EVT_DEF, ERR_DEF,
      FSP_DEF};
   // ctrl bits
   localparam int C_EN_USER = 0;
   localparam int C_EN_NET = 1;
   localparam int C_ALT = 2;
   localparam int C_TERM = 3;
   localparam int C_ASYNC = 4;
   localparam logic [4:0] CTRL_RST = 5'h03;
   // pvc bits
   localparam int P_CFG = 0;
   localparam int P_SEG_OK = 1;
   localparam int P_UNI_OK = 2;
   localparam int P_BIDIR = 3;
   localparam int P_USR_ACT = 4;
   localparam int P_ADD = 5;
   localparam logic [4:0] PVC_RST = 5'h00;
endpackage

//--- common/nps_mon_if.sv
// Purpose: event feed from the manager to a link monitor
// Assumes: ev is a one-cycle pulse
// Notes: one instance per procedure role
`timescale 1ns/10ps
interface nps_mon_if;
   logic ev;
   logic err;
   logic clr;
   logic alt;
   logic [3:0] err_thr;
   logic [3:0] evt_cnt;
   logic op;
   modport mgr (output ev, err, clr, alt, err_thr, evt_cnt, input op);
   modport mon (input ev, err, clr, alt, err_thr, evt_cnt, output op);
endinterface

//--- logic/nps_sec_tick.sv
// Purpose: one-cycle pulse once per second
// Assumes: CYC is the number of ref_clk cycles per second
// Notes: shorten CYC in simulation
`timescale 1ns/10ps
module nps_sec_tick #(
   parameter int CYC = nps_pkg::SEC_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // pulse
   output logic tick
);
   localparam int W = $clog2(CYC + 1);
   typedef struct packed {logic [W-1:0] cnt; logic tick;} nps_tick_type;
   nps_tick_type s_ff, nxt_s;
   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      if (s_ff.cnt == W'(CYC - 1)) begin
         nxt_s.cnt = '0;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.cnt = W'(s_ff.cnt + 1'b1);
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) s_ff <= '0;
      else s_ff <= nxt_s;
   end
   assign tick = s_ff.tick;
   property p_tick_one;
      @(posedge ref_clk) disable iff (sys_rst) tick |=> !tick;
   endproperty
   a_tick_one: assert property (p_tick_one) else $error("second tick longer than a cycle");
endmodule // nps_sec_tick

//--- logic/nps_link_mon.sv
// Purpose: link integrity monitor for one procedure role
// Assumes: ev marks one monitored event, err says it failed
// Notes: sliding window over the last evt_cnt events
`timescale 1ns/10ps
module nps_link_mon #(
   parameter int WIN = nps_pkg::WIN_MAX
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // events and state
   nps_mon_if.mon mi
);
   typedef struct packed {
      logic [WIN-1:0] win;
      logic [3:0] run;
      logic first;
      logic op;
   } nps_mon_type;
   nps_mon_type s_ff, nxt_s;
   always_comb begin
      logic [3:0] errs;
      errs = '0;
      nxt_s = s_ff;
      if (mi.clr) begin
         nxt_s = '0;
      end else if (mi.ev) begin
         nxt_s.win = {s_ff.win[WIN-2:0], mi.err};
         for (int i = 0; i < WIN; i++) begin
            if (4'(i) < mi.evt_cnt && nxt_s.win[i]) errs = 4'(errs + 1'b1);
         end
         nxt_s.run = mi.err ? 4'h0 : (&s_ff.run ? s_ff.run : 4'(s_ff.run + 1'b1));
         nxt_s.first = 1'b1;
         if (errs >= mi.err_thr) nxt_s.op = 1'b0;
         else if (!s_ff.op && nxt_s.run >= mi.evt_cnt) nxt_s.op = 1'b1;
         else if (mi.alt && !s_ff.first && !mi.err) nxt_s.op = 1'b1;
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) s_ff <= '0;
      else s_ff <= nxt_s;
   end
   assign mi.op = s_ff.op;
   property p_op_rise;
      @(posedge ref_clk) disable iff (sys_rst) $rose(mi.op) |-> $past(mi.ev) && !$past(mi.err);
   endproperty
   a_op_rise: assert property (p_op_rise) else $error("channel up without a valid cycle");
   property p_clr_down;
      @(posedge ref_clk) disable iff (sys_rst) mi.clr |=> !mi.op;
   endproperty
   a_clr_down: assert property (p_clr_down) else $error("channel up at activation");
endmodule // nps_link_mon

//--- logic/nps_top.sv
// Purpose: nni link verification and multi-network pvc status manager
// Assumes: message layer reports cycle results as one-cycle pulses
// Notes: apb slave, one wait state on every access
// Operation
// - polling and answering engines run at once, each with its own monitor.
// - full status poll count is programmable 1 to 255, default 6.
// - link declared down when error threshold errors fall in the window.
// - poll timer programmable 5 to 30 seconds, default 10.
// - poll verify timer programmable 5 to 30 seconds, default 15.
// - error threshold should not exceed monitored event count.
// - poll verify timer should exceed poll timer.
// - enquiry on each poll timer expiry, full request every n cycles.
// - both roles share one set of timer and counter values.
// - received report status is forwarded toward the user interface.
// - after a status change the next enquiry gets a full report.
// - channel starts non-operational when a procedure is activated.
// - channel up after monitored event count consecutive valid cycles.
// - optional mode: first valid cycle brings the channel up; here only if the first cycle after activation is valid.
// - active bit 1 only when every criterion holds.
// - criteria: configured, links verified, no faults, remote user active.
// - any failed criterion drives the active bit to 0.
// - only a terminating node originates an active bit of 1.
// - transit node relays the received bit or forces it to 0.
// - added segment reported with its new bit set.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module nps_top #(
   parameter int CYC_PER_SEC = nps_pkg::SEC_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // polling engine
   output logic enq_send,
   output logic enq_full,
   input wire logic cyc_ok,
   input wire logic cyc_err,
   // answering engine
   input wire logic enq_ok,
   input wire logic enq_err,
   input wire logic enq_full_req,
   output logic rpt_send,
   output logic rpt_full,
   output logic rpt_new,
   output logic rpt_act,
   // received pvc status
   input wire logic rx_rpt_valid,
   input wire logic rx_rpt_act,
   // toward the user interface
   output logic uni_active
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [31:0] cfg;
      logic [4:0] ctrl;
      logic [4:0] pvc;
      logic newb;
      logic fpend;
      logic rx_act;
      logic [4:0] t1;
      logic [4:0] t2;
      logic [7:0] polls;
      logic enq_send;
      logic enq_full;
      logic rpt_send;
      logic rpt_full;
      logic rpt_new;
      logic rpt_act;
      logic uni_act;
   } nps_state_type;

   nps_state_type s_ff, nxt_s;
   logic tick;
   logic vexp;
   logic add_wr;
   nps_mon_if usr_if ();
   nps_mon_if net_if ();

   ////////////////////////////////////////////////////////////////////////////////
   // clamp written values into their legal ranges
   function automatic logic [3:0] lim4(input logic [3:0] v);
      lim4 = (v < nps_pkg::CNT_MIN) ? nps_pkg::CNT_MIN : ((v > nps_pkg::CNT_MAX) ?
         nps_pkg::CNT_MAX : v);
   endfunction
   function automatic logic [4:0] lim5(input logic [4:0] v);
      lim5 = (v < nps_pkg::T_MIN_S) ? nps_pkg::T_MIN_S : ((v > nps_pkg::T_MAX_S) ?
         nps_pkg::T_MAX_S : v);
   endfunction
   function automatic logic [31:0] fix_cfg(input logic [31:0] w);
      logic [7:0] fsp;
      fsp = w[nps_pkg::F_FSP +: 8];
      fix_cfg = '0;
      fix_cfg[nps_pkg::F_FSP +: 8] = (fsp < nps_pkg::FSP_MIN) ? nps_pkg::FSP_MIN : fsp;
      fix_cfg[nps_pkg::F_ERR +: 4] = lim4(w[nps_pkg::F_ERR +: 4]);
      fix_cfg[nps_pkg::F_EVT +: 4] = lim4(w[nps_pkg::F_EVT +: 4]);
      fix_cfg[nps_pkg::F_PT +: 5] = lim5(w[nps_pkg::F_PT +: 5]);
      fix_cfg[nps_pkg::F_PVT +: 5] = lim5(w[nps_pkg::F_PVT +: 5]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // field views
   logic [7:0] fsp_cnt;
   logic [3:0] err_thr;
   logic [3:0] evt_cnt;
   logic [4:0] poll_s;
   logic [4:0] verify_s;
   logic cfg_warn;
   logic crit;
   logic chg;
   assign fsp_cnt = s_ff.cfg[nps_pkg::F_FSP +: 8];
   assign err_thr = s_ff.cfg[nps_pkg::F_ERR +: 4];
   assign evt_cnt = s_ff.cfg[nps_pkg::F_EVT +: 4];
   assign poll_s = s_ff.cfg[nps_pkg::F_PT +: 5];
   assign verify_s = s_ff.cfg[nps_pkg::F_PVT +: 5];
   // recommended relations are flagged, not forced, so odd setups stay possible
   assign cfg_warn = (err_thr > evt_cnt) || (verify_s <= poll_s);

   ////////////////////////////////////////////////////////////////////////////////
   // seconds base and the two monitors
   nps_sec_tick #(.CYC(CYC_PER_SEC)) u_tick (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .tick(tick)
   );

   // both roles see the same threshold values
   assign usr_if.ev = cyc_ok | cyc_err;
   assign usr_if.err = cyc_err;
   assign usr_if.clr = !s_ff.ctrl[nps_pkg::C_EN_USER];
   assign usr_if.alt = s_ff.ctrl[nps_pkg::C_ALT];
   assign usr_if.err_thr = err_thr;
   assign usr_if.evt_cnt = evt_cnt;
   assign net_if.ev = enq_ok | enq_err | vexp;
   assign net_if.err = enq_err | vexp;
   assign net_if.clr = !s_ff.ctrl[nps_pkg::C_EN_NET];
   assign net_if.alt = s_ff.ctrl[nps_pkg::C_ALT];
   assign net_if.err_thr = err_thr;
   assign net_if.evt_cnt = evt_cnt;

   nps_link_mon u_usr_mon (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .mi(usr_if.mon)
   );
   nps_link_mon u_net_mon (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .mi(net_if.mon)
   );

   // verify timer expiry without an enquiry
   assign vexp = s_ff.ctrl[nps_pkg::C_EN_NET] && tick && !(enq_ok || enq_err) &&
      (5'(s_ff.t2 + 1'b1) >= verify_s);
   assign add_wr = psel && penable && s_ff.pready && pwrite && (paddr == nps_pkg::A_PVC) &&
      pwdata[nps_pkg::P_ADD];

   // pvc active criteria
   always_comb begin
      crit = s_ff.pvc[nps_pkg::P_CFG] && s_ff.pvc[nps_pkg::P_SEG_OK] &&
         s_ff.pvc[nps_pkg::P_UNI_OK] && usr_if.op && net_if.op;
      crit = crit && (!s_ff.pvc[nps_pkg::P_BIDIR] || s_ff.pvc[nps_pkg::P_USR_ACT]);
      // only a terminating node may originate a 1; transit relays what it received
      if (!s_ff.ctrl[nps_pkg::C_TERM]) begin
         crit = crit && s_ff.rx_act;
      end
   end
   assign chg = (crit != s_ff.uni_act);

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      nxt_s = s_ff;
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;
      nxt_s.enq_send = 1'b0;
      nxt_s.rpt_send = 1'b0;
      // apb: answer one cycle into the access phase
      if (psel && penable && !s_ff.pready) begin
         nxt_s.pready = 1'b1;
         nxt_s.prdata = '0;
         unique case (paddr)
            nps_pkg::A_CFG: nxt_s.prdata = s_ff.cfg;
            nps_pkg::A_CTRL: nxt_s.prdata[4:0] = s_ff.ctrl;
            nps_pkg::A_PVC: nxt_s.prdata[4:0] = s_ff.pvc;
            nps_pkg::A_STAT: nxt_s.prdata[15:0] = {s_ff.polls, 2'b00, cfg_warn, s_ff.fpend,
               s_ff.newb, s_ff.uni_act, net_if.op, usr_if.op};
            default: nxt_s.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && s_ff.pready && pwrite) begin
         unique case (paddr)
            nps_pkg::A_CFG: nxt_s.cfg = fix_cfg(pwdata);
            nps_pkg::A_CTRL: nxt_s.ctrl = pwdata[4:0];
            nps_pkg::A_PVC: nxt_s.pvc = pwdata[4:0];
            default: ;
         endcase
      end
      // polling engine
      if (!s_ff.ctrl[nps_pkg::C_EN_USER]) begin
         nxt_s.t1 = '0;
         nxt_s.polls = '0;
      end else if (tick) begin
         if (5'(s_ff.t1 + 1'b1) >= poll_s) begin
            nxt_s.t1 = '0;
            nxt_s.enq_send = 1'b1;
            if (8'(s_ff.polls + 1'b1) >= fsp_cnt) begin
               nxt_s.polls = '0;
               nxt_s.enq_full = 1'b1;
            end else begin
               nxt_s.polls = 8'(s_ff.polls + 1'b1);
               nxt_s.enq_full = 1'b0;
            end
         end else begin
            nxt_s.t1 = 5'(s_ff.t1 + 1'b1);
         end
      end
      // answering engine verify timer
      if (!s_ff.ctrl[nps_pkg::C_EN_NET] || enq_ok || enq_err || vexp) begin
         nxt_s.t2 = '0;
      end else if (tick) begin
         nxt_s.t2 = 5'(s_ff.t2 + 1'b1);
      end
      // status from the far network
      if (rx_rpt_valid) begin
         nxt_s.rx_act = rx_rpt_act;
      end
      nxt_s.uni_act = crit;
      // reports: a full one clears the pending flags first, new events set them after
      if (enq_ok) begin
         nxt_s.rpt_send = 1'b1;
         nxt_s.rpt_full = enq_full_req || s_ff.fpend;
         nxt_s.rpt_new = s_ff.newb && (enq_full_req || s_ff.fpend);
         nxt_s.rpt_act = s_ff.uni_act;
         if (enq_full_req || s_ff.fpend) begin
            nxt_s.fpend = 1'b0;
            nxt_s.newb = 1'b0;
         end
      end else if (s_ff.ctrl[nps_pkg::C_ASYNC] && chg) begin
         nxt_s.rpt_send = 1'b1;
         nxt_s.rpt_full = 1'b0;
         nxt_s.rpt_new = 1'b0;
         nxt_s.rpt_act = crit;
      end
      if (chg || add_wr) begin
         nxt_s.fpend = 1'b1;
      end
      if (add_wr) begin
         nxt_s.newb = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_ff <= '0;
         s_ff.cfg <= nps_pkg::CFG_RST;
         s_ff.ctrl <= nps_pkg::CTRL_RST;
         s_ff.pvc <= nps_pkg::PVC_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign enq_send = s_ff.enq_send;
   assign enq_full = s_ff.enq_full;
   assign rpt_send = s_ff.rpt_send;
   assign rpt_full = s_ff.rpt_full;
   assign rpt_new = s_ff.rpt_new;
   assign rpt_act = s_ff.rpt_act;
   assign uni_active = s_ff.uni_act;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_full_wrap;
      @(posedge ref_clk) disable iff (sys_rst) enq_send |-> (enq_full == (s_ff.polls == 8'h00));
   endproperty
   a_full_wrap: assert property (p_full_wrap) else $error("full request off its cycle");
   property p_poll_tick;
      @(posedge ref_clk) disable iff (sys_rst) enq_send |-> $past(tick);
   endproperty
   a_poll_tick: assert property (p_poll_tick) else $error("enquiry not on a second");
   property p_down_drop;
      @(posedge ref_clk) disable iff (sys_rst) !(usr_if.op && net_if.op) |=> !uni_active;
   endproperty
   a_down_drop: assert property (p_down_drop) else $error("active while link down");
   property p_act_cfg;
      @(posedge ref_clk) disable iff (sys_rst)
         uni_active |-> $past(s_ff.pvc[nps_pkg::P_CFG] && s_ff.pvc[nps_pkg::P_SEG_OK]);
   endproperty
   a_act_cfg: assert property (p_act_cfg) else $error("active on a bad segment");
   sequence s_enq_pend;
      s_ff.fpend && enq_ok;
   endsequence
   property p_full_after_chg;
      @(posedge ref_clk) disable iff (sys_rst) s_enq_pend |=> rpt_send && rpt_full;
   endproperty
   a_full_after_chg: assert property (p_full_after_chg)
      else $error("pending full not sent");
   property p_add_new;
      @(posedge ref_clk) disable iff (sys_rst) add_wr |=> s_ff.newb && s_ff.fpend;
   endproperty
   a_add_new: assert property (p_add_new) else $error("add not flagged new");
endmodule // nps_top

//--- verification/nps_peer.sv
// Purpose: adjacent network node that answers the device's status polls
// Assumes: one answer per enquiry, prompt or about six cycles late
// Notes: answers wrongly only while the bench holds ans_bad
`timescale 1ns/10ps
module nps_peer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // bench control
   input wire logic ans_bad,
   input wire logic ans_slow,
   // device polling engine
   input wire logic enq_send,
   output logic cyc_ok,
   output logic cyc_err
);
////////////////////////////////////////////////////////////
   logic pend_ff;
   logic [2:0] wait_ff;
   // a bad answer stands for a report with a stale sequence number
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_ff <= 1'b0;
         wait_ff <= 3'h0;
         cyc_ok <= 1'b0;
         cyc_err <= 1'b0;
      end else begin
         cyc_ok <= 1'b0;
         cyc_err <= 1'b0;
         if (enq_send) begin
            pend_ff <= 1'b1;
            wait_ff <= ans_slow ? 3'h5 : 3'h0;
         end else if (pend_ff && wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
         end else if (pend_ff) begin
            pend_ff <= 1'b0;
            cyc_ok <= !ans_bad;
            cyc_err <= ans_bad;
         end
      end
   end
endmodule // nps_peer

//--- verification/tb_top.sv
// Purpose: self-checking bench for the pvc status manager
// Assumes: one second shortened to 20 ref_clk cycles
// Notes: bench plays the peer's enquiries, nps_peer answers polls
`timescale 1ns/10ps
module tb_top;
////////////////////////////////////////////////////////////
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, (got), (exp)); end end
   logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat, x, y;
   logic enq_send, enq_full, cyc_ok, cyc_err, enq_ok, enq_err, enq_full_req;
   logic rpt_send, rpt_full, rpt_new, rpt_act, rx_rpt_valid, rx_rpt_act, uni_active;
   logic ans_bad, ans_slow, rerr, last, term, rxa;
   int n_errors = 0;
   int comparisons = 0;
   int gap = 0;
   int pn, i;
   integer seed = 67;
   nps_top #(.CYC_PER_SEC(20)) u_nps_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .enq_send(enq_send),
      .enq_full(enq_full), .cyc_ok(cyc_ok), .cyc_err(cyc_err), .enq_ok(enq_ok),
      .enq_err(enq_err), .enq_full_req(enq_full_req), .rpt_send(rpt_send),
      .rpt_full(rpt_full), .rpt_new(rpt_new), .rpt_act(rpt_act),
      .rx_rpt_valid(rx_rpt_valid), .rx_rpt_act(rx_rpt_act), .uni_active(uni_active));
   nps_peer u_nps_peer (.ref_clk(ref_clk), .sys_rst(sys_rst), .ans_bad(ans_bad),
      .ans_slow(ans_slow), .enq_send(enq_send), .cyc_ok(cyc_ok), .cyc_err(cyc_err));
   always #20 ref_clk = ~ref_clk;
   // cycles since the last enquiry, read at the edge that sees the next one
   always @(posedge ref_clk) gap <= (enq_send === 1'b1) ? 1 : gap + 1;
   task automatic report_and_stop();
      if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic tmo();
      n_errors++;
      $display("CHECK FAILED %0t no answer", $time);
      report_and_stop();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) tmo();
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wpoll();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (enq_send !== 1'b1 && n < 400);
      if (n >= 400) tmo();
      pn = gap;
   endtask
   // wait covers the peer's answer delay plus one cycle for the monitor
   task automatic pstat(input int w);
      wpoll();
      repeat (w) @(posedge ref_clk);
      apb(1'b0, nps_pkg::A_STAT, 32'h0);
   endtask
   task automatic enq(input logic full, input logic bad, input logic xf, input logic xn);
      enq_ok <= !bad;
      enq_err <= bad;
      enq_full_req <= full;
      @(posedge ref_clk);
      enq_ok <= 1'b0;
      enq_err <= 1'b0;
      enq_full_req <= ~full;
      @(posedge ref_clk);
      `CHK(rpt_send, !bad)
      if (!bad) begin
         `CHK(rpt_full, xf)
         `CHK(rpt_new, xn)
      end
   endtask
   function automatic logic [4:0] lim(logic [4:0] v, logic [4:0] lo, logic [4:0] hi);
      return (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction
   function automatic logic [31:0] clamp(logic [31:0] v);
      logic [4:0] b;
      logic [4:0] c;
      b = lim({1'b0, v[11:8]}, 5'h01, 5'h0a);
      c = lim({1'b0, v[15:12]}, 5'h01, 5'h0a);
      return {6'h00, lim(v[25:21], nps_pkg::T_MIN_S, nps_pkg::T_MAX_S),
         lim(v[20:16], nps_pkg::T_MIN_S, nps_pkg::T_MAX_S), c[3:0], b[3:0],
         (v[7:0] == 8'h00) ? nps_pkg::FSP_MIN : v[7:0]};
   endfunction
   function automatic logic exp_act(logic [4:0] p, logic t, logic r);
      return p[0] & p[1] & p[2] & (~p[3] | p[4]) & (t | r);
   endfunction
////////////////////////////////////////////////////////////
   initial begin
      {ref_clk, psel, penable, pwrite, paddr, pwdata} = '0;
      {enq_ok, enq_err, enq_full_req, rx_rpt_valid, rx_rpt_act, ans_bad, ans_slow} = '0;
      sys_rst = 1'b1;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, nps_pkg::A_CFG, 32'h0);
      `CHK(rdat, nps_pkg::CFG_RST)
      apb(1'b0, nps_pkg::A_CTRL, 32'h0);
      `CHK(rdat, {27'h0, nps_pkg::CTRL_RST})
      apb(1'b0, nps_pkg::A_STAT, 32'h0);
      `CHK(rdat, 32'h0)
      apb(1'b0, nps_pkg::A_PVC, 32'h0);
      `CHK(rdat, 32'h0)
      apb(1'b0, 8'h10, 32'h0);
      `CHK({rerr, rdat}, 33'h1_0000_0000)
      apb(1'b1, 8'h10, 32'hffffffff);
      `CHK(rerr, 1'b1)
      apb(1'b1, nps_pkg::A_CTRL, 32'h1c);
      apb(1'b0, nps_pkg::A_CTRL, 32'h0);
      `CHK(rdat, 32'h1c)
      apb(1'b1, nps_pkg::A_CTRL, 32'h0);
      for (i = 0; i < 8; i++) begin
         x = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
         y = clamp(x);
         apb(1'b1, nps_pkg::A_CFG, x);
         apb(1'b0, nps_pkg::A_CFG, 32'h0);
         `CHK(rdat, y)
         apb(1'b0, nps_pkg::A_STAT, 32'h0);
         `CHK(rdat[5], (y[11:8] > y[15:12]) | (y[25:21] <= y[20:16]))
      end
      // full every 2 polls, 3 errors in 4 events, poll 5 s, verify 15 s
      apb(1'b1, nps_pkg::A_CFG, 32'h01e54302);
      apb(1'b1, nps_pkg::A_CTRL, 32'h3);
      pstat(8);
      `CHK(rdat[0], 1'b0)
      last = enq_full;
      for (i = 1; i < 5; i++) begin
         pstat(8);
         `CHK(pn, 100)
         `CHK(enq_full, ~last)
         `CHK(rdat[0], 1'(i >= 3))
         last = enq_full;
      end
      enq(1'b0, 1'b1, 1'b0, 1'b0);
      enq(1'b0, 1'b0, 1'b0, 1'b0);
      enq(1'b1, 1'b0, 1'b1, 1'b0);
      apb(1'b1, nps_pkg::A_PVC, 32'h21);
      enq(1'b0, 1'b0, 1'b1, 1'b1);
      apb(1'b0, nps_pkg::A_STAT, 32'h0);
      `CHK(rdat[1:0], 2'b01)
      enq(1'b0, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge ref_clk);
      apb(1'b0, nps_pkg::A_STAT, 32'h0);
      `CHK(rdat[1:0], 2'b11)
      for (i = 0; i < 12; i++) begin
         x = (i == 0) ? 32'h11f : (i == 1) ? 32'h21f : (i == 2) ? 32'h20f : $random(seed);
         term = x[8];
         rxa = x[9];
         apb(1'b1, nps_pkg::A_CTRL, {28'h0, term, 3'h3});
         apb(1'b1, nps_pkg::A_PVC, {27'h0, x[4:0]});
         rx_rpt_valid <= 1'b1;
         rx_rpt_act <= rxa;
         @(posedge ref_clk);
         rx_rpt_valid <= 1'b0;
         rx_rpt_act <= ~rxa;
         repeat (2) @(posedge ref_clk);
         `CHK(uni_active, exp_act(x[4:0], term, rxa))
         enq(1'b1, 1'b0, 1'b1, 1'b0);
         `CHK(rpt_act, exp_act(x[4:0], term, rxa))
      end
      apb(1'b1, nps_pkg::A_CTRL, 32'hb);
      apb(1'b1, nps_pkg::A_PVC, 32'h7);
      repeat (2) @(posedge ref_clk);
      `CHK(uni_active, 1'b1)
      ans_bad <= 1'b1;
      for (i = 1; i < 4; i++) begin
         pstat(8);
         `CHK(rdat[0], 1'(i < 3))
      end
      `CHK(uni_active, 1'b0)
      apb(1'b1, nps_pkg::A_CTRL, 32'h0);
      apb(1'b1, nps_pkg::A_CTRL, 32'h7);
      ans_bad <= 1'b0;
      ans_slow <= 1'b1;
      pstat(10);
      `CHK(rdat[0], 1'b1)
      report_and_stop();
   end
endmodule // tb_top
